// *** core/seq_pkg.sv ***
package seq_pkg;
  // timing base
  localparam int CLK_HZ = 10_000_000;
  localparam int TICK_S = 1;
  localparam int SEC_CYCLES = CLK_HZ * TICK_S;
  localparam int I2C_HZ = 100_000;
  localparam int I2C_QTR_CYCLES = CLK_HZ / (4 * I2C_HZ);
  localparam logic [2:0] STRAP_DELAY_CYCLES = 3'h4;
  // sequencer durations
  localparam int SILENCE_STANDBY_STATE_MIN = 8;
  localparam int STANDBY_STATE_OFF_MIN = 2;
  localparam int MUTE_OFF_MIN = 10;
  localparam int BACKLIGHT_S = 15;
  localparam logic [15:0] SILENCE_STANDBY_STATE_RST = 16'(SILENCE_STANDBY_STATE_MIN * 60);
  localparam logic [15:0] STANDBY_STATE_OFF_RST = 16'(STANDBY_STATE_OFF_MIN * 60);
  localparam logic [15:0] MUTE_OFF_RST = 16'(MUTE_OFF_MIN * 60);
  localparam logic [15:0] BACKLIGHT_RST = 16'(BACKLIGHT_S);
  // register reset values
  localparam logic [7:0] THRESH_RST = 8'h10;
  localparam logic [7:0] OFF_TEMP_RST = 8'h46;
  localparam logic [3:0] HYST_RST = 4'h4;
  localparam logic [6:0] I2C_ADDR_RST = 7'h27;
  localparam logic [7:0] LOGO_RST = 8'h00;
  // register offsets and last display byte index
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] TIME0_OFS = 8'h04;
  localparam logic [7:0] TIME1_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0c;
  localparam logic [7:0] DISP_OFS = 8'h10;
  localparam logic [2:0] DISP_LAST = 3'h4;
  // states
  typedef enum logic [4:0] {
    ST_ON = 5'h01,
    ST_MUTE = 5'h02,
    ST_STANDBY = 5'h04,
    ST_OFF = 5'h08,
    ST_HOT = 5'h10
  } seq_state_t;
  // register layouts
  typedef struct packed {
    logic [11:0] rsvd;
    logic [3:0] hyst;
    logic [7:0] offTemp;
    logic [7:0] thresh;
  } ctrl_t;
  typedef struct packed {
    logic [15:0] hi;
    logic [15:0] lo;
  } time_t;
  typedef struct packed {
    logic [7:0] rsvd;
    logic [7:0] temp;
    logic [7:0] level;
    logic nack;
    logic hot;
    logic autoDetect;
    seq_state_t state;
  } status_t;
  typedef struct packed {
    logic [16:0] rsvd;
    logic [6:0] addr;
    logic [7:0] logo;
  } disp_t;
endpackage

// *** core/disp_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface disp_if;
  logic valid;
  logic ready;
  logic last;
  logic nack;
  logic [7:0] data;
  modport src(output valid, output last, output data, input ready, input nack);
  modport snk(input valid, input last, input data, output ready, output nack);
endinterface
`default_nettype wire

// *** core/disp_i2c_tx.sv ***
`timescale 1ns/1ps
`default_nettype none
module disp_i2c_tx import seq_pkg::*; #(
  parameter int QTR_CYCLES = I2C_QTR_CYCLES
) (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // byte stream
  disp_if.snk bus,
  // open-drain pins, oe low drives low
  input wire logic sdaIn,
  output logic sclOe_n,
  output logic sdaOe_n
);
  localparam int QW = $clog2(QTR_CYCLES + 1);
  typedef enum logic [3:0] {
    TX_IDLE = 4'h1,
    TX_START = 4'h2,
    TX_BIT = 4'h4,
    TX_STOP = 4'h8
  } tx_state_t;
  tx_state_t txState_reg;
  logic [QW-1:0] qCnt_reg;
  logic [1:0] phase_reg;
  logic [3:0] bitIdx_reg;
  logic [7:0] shift_reg;
  logic last_reg;
  logic nack_reg;
  wire qTick = qCnt_reg == QW'(QTR_CYCLES - 1);
  wire ackSlot = bitIdx_reg == 4'h8;
  wire byteEnd = txState_reg == TX_BIT && qTick && phase_reg == 2'h3 && ackSlot;
  wire takeFirst = txState_reg == TX_IDLE && bus.valid;
  wire takeNext = byteEnd && !last_reg && bus.valid;
  assign bus.ready = takeFirst | takeNext;
  assign bus.nack = nack_reg;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      qCnt_reg <= '0;
    end else begin
      qCnt_reg <= (txState_reg == TX_IDLE || qTick) ? '0 : qCnt_reg + 1'b1;
    end
  end
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      txState_reg <= TX_IDLE;
      phase_reg <= 2'h0;
      bitIdx_reg <= 4'h0;
      shift_reg <= 8'h00;
      last_reg <= 1'b0;
      nack_reg <= 1'b0;
      sclOe_n <= 1'b1;
      sdaOe_n <= 1'b1;
    end else begin
      nack_reg <= byteEnd && sdaIn;
      if (bus.ready) begin
        shift_reg <= bus.data;
        last_reg <= bus.last;
        bitIdx_reg <= 4'h0;
      end
      unique case (txState_reg)
        TX_IDLE: begin
          if (takeFirst) begin
            sdaOe_n <= 1'b0;
            phase_reg <= 2'h0;
            txState_reg <= TX_START;
          end
        end
        TX_START: begin
          if (qTick) begin
            txState_reg <= TX_BIT;
          end
        end
        TX_BIT: begin
          if (qTick) begin
            phase_reg <= phase_reg + 2'h1;
            unique case (phase_reg)
              2'h0: sclOe_n <= 1'b0;
              2'h1: sdaOe_n <= ackSlot | shift_reg[7];
              2'h2: sclOe_n <= 1'b1;
              2'h3: begin
                if (!ackSlot) begin
                  shift_reg <= {shift_reg[6:0], 1'b0};
                  bitIdx_reg <= bitIdx_reg + 4'h1;
                end else if (!takeNext) begin
                  txState_reg <= TX_STOP;
                end
              end
            endcase
          end
        end
        TX_STOP: begin
          if (qTick) begin
            phase_reg <= phase_reg + 2'h1;
            unique case (phase_reg)
              2'h0: sclOe_n <= 1'b0;
              2'h1: sdaOe_n <= 1'b0;
              2'h2: sclOe_n <= 1'b1;
              2'h3: begin
                sdaOe_n <= 1'b1;
                txState_reg <= TX_IDLE;
              end
            endcase
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// *** core/audio_standby_sequencer.sv ***
`timescale 1ns/1ps
`default_nettype none
// Operation
// - sample mute line after reset; floating enables autodetect until next power-up
// - autodetect: audio above threshold turns the system on
// - autodetect: stay on while audio stays above threshold
// - autodetect: silence for the standby time moves on to standby
// - in standby, a further silent interval switches the system off
// - manual: mute line low longer than the mute-off time switches off
// - threshold and all durations are software registers
// - mute, standby and off show distinct patterns on the status led
// - i2c display shows mode, temperature, audio level and logo
// - over-temperature switches everything off, reactivates after cooling
// - over-temperature lights the second indicator and shows on display
// - two remote on/off outputs follow the system state
// - off state disables the internal supply
// - display backlight turns off a set time after entering off
// - sub connection carries mute and standby lines for amplifiers
module audio_standby_sequencer import seq_pkg::*; #(
  parameter int SEC_CYCLES_P = SEC_CYCLES,
  parameter int QTR_CYCLES_P = I2C_QTR_CYCLES
) (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // sensing pins
  input wire logic muteLineIn,
  input wire logic [7:0] audioLevelIn,
  input wire logic [7:0] tempIn,
  // power and amplifier control
  output logic [1:0] remoteOn,
  output logic subMute_n,
  output logic standbyControlLine_n,
  output logic supplyEn,
  // indicators
  output logic statusLed,
  output logic secondStatusIndicator,
  output logic backlightEn,
  // display bus
  input wire logic sdaIn,
  output logic sclOe_n,
  output logic sdaOe_n
);
  localparam int HALF = SEC_CYCLES_P / 2;
  localparam int PRE_W = $clog2(HALF + 1);

  // input synchronisers
  logic [17:0] syncA_reg;
  logic [17:0] syncB_reg;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      syncA_reg <= '0;
      syncB_reg <= '0;
    end else begin
      syncA_reg <= {sdaIn, muteLineIn, audioLevelIn, tempIn};
      syncB_reg <= syncA_reg;
    end
  end
  wire sdaS = syncB_reg[17];
  wire muteS = syncB_reg[16];
  wire [7:0] audioS = syncB_reg[15:8];
  wire [7:0] tempS = syncB_reg[7:0];

  // registers
  ctrl_t ctrl_reg;
  time_t time0_reg;
  time_t time1_reg;
  disp_t disp_reg;
  logic nack_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;

  // sequencer state
  seq_state_t state_reg;
  seq_state_t state_next;
  logic [2:0] strapCnt_reg;
  logic strapDone_reg;
  logic autoDetect_reg;
  logic hot_reg;
  logic [PRE_W-1:0] preCnt_reg;
  logic halfPhase_reg;
  logic secPhase_reg;
  logic [15:0] secCount_reg;
  logic [15:0] blCount_reg;
  logic [2:0] dispIdx_reg;
  logic dispBusy_reg;
  logic [1:0] remoteOn_reg;
  logic subMute_n_reg;
  logic standby_n_reg;
  logic supplyEn_reg;
  logic statusLed_reg;
  logic second_reg;
  logic backlight_reg;

  // apb decode
  wire apbAccess = psel & penable;
  wire apbFirst = apbAccess & ~pready_reg;
  wire apbDone = apbAccess & pready_reg;
  wire selCtrl = paddr == CTRL_OFS;
  wire selTime0 = paddr == TIME0_OFS;
  wire selTime1 = paddr == TIME1_OFS;
  wire selStatus = paddr == STATUS_OFS;
  wire selDisp = paddr == DISP_OFS;
  wire mapped = selCtrl | selTime0 | selTime1 | selStatus | selDisp;
  wire wrEn = apbDone & pwrite & ~pslverr_reg;
  status_t statusView;
  status_t statusWr;
  assign statusView = '{rsvd: 8'h00, temp: tempS, level: audioS, nack: nack_reg,
                        hot: hot_reg, autoDetect: autoDetect_reg, state: state_reg};
  assign statusWr = status_t'(pwdata);
  wire [31:0] rdMux = selCtrl ? ctrl_reg :
                      selTime0 ? time0_reg :
                      selTime1 ? time1_reg :
                      selStatus ? statusView :
                      selDisp ? disp_reg : 32'h0000_0000;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      pready_reg <= apbFirst;
      pslverr_reg <= apbFirst & ~mapped;
      if (apbFirst) begin
        prdata_reg <= rdMux;
      end
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_reg <= '{rsvd: 12'h000, hyst: HYST_RST, offTemp: OFF_TEMP_RST,
                    thresh: THRESH_RST};
      time0_reg <= '{hi: STANDBY_STATE_OFF_RST, lo: SILENCE_STANDBY_STATE_RST};
      time1_reg <= '{hi: BACKLIGHT_RST, lo: MUTE_OFF_RST};
      disp_reg <= '{rsvd: 17'h00000, addr: I2C_ADDR_RST, logo: LOGO_RST};
    end else if (wrEn) begin
      if (selCtrl) begin
        ctrl_reg <= '{rsvd: 12'h000, hyst: pwdata[19:16], offTemp: pwdata[15:8],
                      thresh: pwdata[7:0]};
      end
      if (selTime0) begin
        time0_reg <= time_t'(pwdata);
      end
      if (selTime1) begin
        time1_reg <= time_t'(pwdata);
      end
      if (selDisp) begin
        disp_reg <= '{rsvd: 17'h00000, addr: pwdata[14:8], logo: pwdata[7:0]};
      end
    end
  end

  // display nack flag, set wins over clear
  disp_if dbus();
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      nack_reg <= 1'b0;
    end else begin
      nack_reg <= dbus.nack | (nack_reg & ~(wrEn & selStatus & statusWr.nack));
    end
  end

  // power-up strap of the mute line
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      strapCnt_reg <= 3'h0;
      strapDone_reg <= 1'b0;
      autoDetect_reg <= 1'b0;
    end else if (!strapDone_reg) begin
      strapCnt_reg <= strapCnt_reg + 3'h1;
      if (strapCnt_reg == STRAP_DELAY_CYCLES) begin
        strapDone_reg <= 1'b1;
        autoDetect_reg <= muteS;
      end
    end
  end

  // second and half-second ticks
  wire halfTick = preCnt_reg == PRE_W'(HALF - 1);
  wire secTick = halfTick & halfPhase_reg;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      preCnt_reg <= '0;
      halfPhase_reg <= 1'b0;
      secPhase_reg <= 1'b0;
    end else begin
      preCnt_reg <= halfTick ? '0 : preCnt_reg + 1'b1;
      halfPhase_reg <= halfPhase_reg ^ halfTick;
      secPhase_reg <= secPhase_reg ^ secTick;
    end
  end

  // over-temperature with hysteresis
  wire hotSet = tempS >= ctrl_reg.offTemp;
  wire [8:0] coolSum = {1'b0, tempS} + {5'h00, ctrl_reg.hyst};
  wire hotClr = coolSum < {1'b0, ctrl_reg.offTemp};
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      hot_reg <= 1'b0;
    end else begin
      hot_reg <= hotSet | (hot_reg & ~hotClr);
    end
  end

  // state transitions
  wire audioHi = audioS > ctrl_reg.thresh;
  wire silentFor = secCount_reg > time0_reg.lo;
  wire idleFor = secCount_reg > time0_reg.hi;
  wire muteFor = secCount_reg > time1_reg.lo;
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_OFF: begin
        if (autoDetect_reg ? audioHi : muteS) begin
          state_next = ST_ON;
        end
      end
      ST_ON: begin
        if (autoDetect_reg) begin
          if (!audioHi && silentFor) begin
            state_next = ST_STANDBY;
          end
        end else if (!muteS) begin
          state_next = ST_MUTE;
        end
      end
      ST_MUTE: begin
        if (muteS) begin
          state_next = ST_ON;
        end else if (muteFor) begin
          state_next = ST_OFF;
        end
      end
      ST_STANDBY: begin
        if (audioHi) begin
          state_next = ST_ON;
        end else if (idleFor) begin
          state_next = ST_OFF;
        end
      end
      ST_HOT: begin
        if (!hot_reg) begin
          state_next = ST_ON;
        end
      end
    endcase
    if (hot_reg) begin
      state_next = ST_HOT;
    end
    if (!strapDone_reg) begin
      state_next = ST_OFF;
    end
  end

  wire stateChange = state_next != state_reg;
  wire countClr = stateChange | (autoDetect_reg & audioHi);
  wire isDown = state_reg == ST_OFF || state_reg == ST_HOT;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= ST_OFF;
      secCount_reg <= 16'h0000;
      blCount_reg <= 16'h0000;
    end else begin
      state_reg <= state_next;
      if (countClr) begin
        secCount_reg <= 16'h0000;
      end else if (secTick && secCount_reg != 16'hffff) begin
        secCount_reg <= secCount_reg + 16'h0001;
      end
      if (!isDown) begin
        blCount_reg <= 16'h0000;
      end else if (secTick && blCount_reg != 16'hffff) begin
        blCount_reg <= blCount_reg + 16'h0001;
      end
    end
  end

  // output decode
  wire onLike = state_reg == ST_ON || state_reg == ST_MUTE || state_reg == ST_STANDBY;
  wire muteLike = state_reg != ST_ON;
  wire standbyLike = state_reg == ST_STANDBY || isDown;
  wire ledPattern = state_reg == ST_ON ? 1'b1 :
                    state_reg == ST_MUTE ? halfPhase_reg :
                    state_reg == ST_STANDBY ? secPhase_reg :
                    state_reg == ST_OFF ? (halfPhase_reg & secPhase_reg) : 1'b0;
  wire blOn = !isDown || blCount_reg < time1_reg.hi;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      remoteOn_reg <= 2'b00;
      subMute_n_reg <= 1'b0;
      standby_n_reg <= 1'b0;
      supplyEn_reg <= 1'b0;
      statusLed_reg <= 1'b0;
      second_reg <= 1'b0;
      backlight_reg <= 1'b0;
    end else begin
      remoteOn_reg <= {2{onLike}};
      subMute_n_reg <= !muteLike;
      standby_n_reg <= !standbyLike;
      supplyEn_reg <= !isDown;
      statusLed_reg <= ledPattern;
      second_reg <= hot_reg;
      backlight_reg <= blOn;
    end
  end

  // display refresh once per second
  wire dispTake = dbus.valid & dbus.ready;
  assign dbus.valid = dispBusy_reg;
  assign dbus.last = dispIdx_reg == DISP_LAST;
  assign dbus.data = dispIdx_reg == 3'h0 ? {disp_reg.addr, 1'b0} :
                     dispIdx_reg == 3'h1 ? {3'b000, state_reg} :
                     dispIdx_reg == 3'h2 ? tempS :
                     dispIdx_reg == 3'h3 ? audioS : disp_reg.logo;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      dispBusy_reg <= 1'b0;
      dispIdx_reg <= 3'h0;
    end else if (!dispBusy_reg) begin
      dispBusy_reg <= secTick;
      dispIdx_reg <= 3'h0;
    end else if (dispTake) begin
      dispBusy_reg <= !dbus.last;
      dispIdx_reg <= dispIdx_reg + 3'h1;
    end
  end

  disp_i2c_tx #(.QTR_CYCLES(QTR_CYCLES_P)) dispTx (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .bus(dbus.snk),
    .sdaIn(sdaS),
    .sclOe_n(sclOe_n),
    .sdaOe_n(sdaOe_n)
  );

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign remoteOn = remoteOn_reg;
  assign subMute_n = subMute_n_reg;
  assign standbyControlLine_n = standby_n_reg;
  assign supplyEn = supplyEn_reg;
  assign statusLed = statusLed_reg;
  assign secondStatusIndicator = second_reg;
  assign backlightEn = backlight_reg;

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  strap_sample_a: assert property (
    $rose(strapDone_reg) |-> autoDetect_reg == $past(muteS))
    else $error("strap not taken from mute line");
  auto_wake_a: assert property (
    strapDone_reg && autoDetect_reg && !hot_reg && state_reg == ST_OFF && audioHi
    |=> state_reg == ST_ON)
    else $error("audio did not wake system");
  stay_on_a: assert property (
    state_reg == ST_ON && autoDetect_reg && audioHi && !hot_reg |=> state_reg == ST_ON)
    else $error("left on while audio present");
  standby_time_a: assert property (
    state_reg == ST_STANDBY && $past(state_reg) == ST_ON
    |-> $past(secCount_reg) > time0_reg.lo && !$past(audioHi))
    else $error("standby entered early");
  off_time_a: assert property (
    state_reg == ST_OFF && $past(state_reg) == ST_STANDBY
    |-> $past(secCount_reg) > time0_reg.hi)
    else $error("off entered early from standby");
  mute_off_a: assert property (
    state_reg == ST_OFF && $past(state_reg) == ST_MUTE
    |-> $past(secCount_reg) > time1_reg.lo)
    else $error("off entered early from mute");
  led_pattern_a: assert property (
    state_reg == ST_ON && !stateChange |=> statusLed)
    else $error("status led dark while on");
  hot_off_a: assert property (
    strapDone_reg && hot_reg |=> state_reg == ST_HOT ##1 remoteOn == 2'b00 && !supplyEn)
    else $error("over-temperature did not switch off");
  second_led_a: assert property (
    hot_reg |-> ##1 secondStatusIndicator)
    else $error("second indicator not lit");
  supply_off_a: assert property (
    state_reg == ST_OFF |=> !supplyEn && remoteOn == 2'b00)
    else $error("supply left on in off");
  backlight_a: assert property (
    $fell(backlightEn) |-> $past(blCount_reg) >= time1_reg.hi)
    else $error("backlight turned off early");
  sub_lines_a: assert property (
    state_reg == ST_STANDBY |=> !standbyControlLine_n && !subMute_n)
    else $error("amplifier lines wrong in standby");
  mute_enter_a: assert property (
    strapDone_reg && !autoDetect_reg && !hot_reg && state_reg == ST_ON && !muteS
    |=> state_reg == ST_MUTE)
    else $error("mute not entered");
  standby_c: cover property (state_reg == ST_ON ##1 state_reg == ST_STANDBY);
  off_c: cover property (state_reg == ST_STANDBY ##1 state_reg == ST_OFF);
  hot_c: cover property (state_reg == ST_HOT ##1 state_reg == ST_ON);
  apb_c: cover property (apbDone && !pwrite && selStatus);
endmodule
`default_nettype wire

// *** dv/disp_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module disp_model (
  // open-drain enables from the block, nack mode from the test
  input wire logic sclOe_n,
  input wire logic sdaOe_n,
  input wire logic nackMode,
  // resolved lines and byte log
  output logic sdaLine,
  output logic sclLine,
  output int nBytes,
  output logic [7:0] addrByte
);
  logic ackDrive = 1'b0;
  logic [7:0] sh = 8'h00;
  int bitIx = 0;
  int byteIx = 0;
  // pull-ups on both lines
  assign sclLine = sclOe_n;
  assign sdaLine = sdaOe_n & ~ackDrive;
  initial nBytes = 0;
  // start condition restarts framing
  always @(negedge sdaLine) if (sclLine) begin
    bitIx = 0;
    byteIx = 0;
  end
  always @(posedge sclLine) begin
    if (bitIx < 8) sh = {sh[6:0], sdaLine};
    bitIx++;
    if (bitIx == 8) begin
      if (byteIx == 0) addrByte = sh;
      byteIx++;
      nBytes++;
    end
  end
  // ack slot, withheld in nack mode
  always @(negedge sclLine) begin
    if (bitIx == 9) bitIx = 0;
    ackDrive = (bitIx == 8) && !nackMode;
  end
endmodule
`default_nettype wire

// *** dv/audio_standby_sequencer_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module audio_standby_sequencer_test import seq_pkg::*;;
  localparam int S = 20;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic muteLineIn = 1'b1;
  logic [7:0] audioLevelIn = 8'h00;
  logic [7:0] tempIn = 8'h19;
  logic [1:0] remoteOn;
  logic subMute_n;
  logic standbyControlLine_n;
  logic supplyEn;
  logic statusLed;
  logic secondStatusIndicator;
  logic backlightEn;
  logic sdaLine;
  logic sclLine;
  logic sclOe_n;
  logic sdaOe_n;
  logic nackMode = 1'b0;
  logic [7:0] addrByte;
  logic [31:0] rdat;
  logic perr;
  int nBytes;
  int cyc = 0;
  int t0;
  int fail_count = 0;
  int n_compared = 0;
  audio_standby_sequencer #(.SEC_CYCLES_P(S), .QTR_CYCLES_P(2)) audio_standby_sequencer_i (
    .mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .muteLineIn(muteLineIn), .audioLevelIn(audioLevelIn), .tempIn(tempIn),
    .remoteOn(remoteOn), .subMute_n(subMute_n), .standbyControlLine_n(standbyControlLine_n),
    .supplyEn(supplyEn), .statusLed(statusLed), .secondStatusIndicator(secondStatusIndicator),
    .backlightEn(backlightEn), .sdaIn(sdaLine), .sclOe_n(sclOe_n), .sdaOe_n(sdaOe_n));
  disp_model disp_model_i (.sclOe_n(sclOe_n), .sdaOe_n(sdaOe_n), .nackMode(nackMode),
    .sdaLine(sdaLine), .sclLine(sclLine), .nBytes(nBytes), .addrByte(addrByte));
  always #50 mclk = ~mclk;
  always @(posedge mclk) cyc <= cyc + 1;
  task automatic conclude();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rst();
    sys_rst <= 1'b1;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (10) @(posedge mclk);
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdat = prdata;
    perr = pslverr;
    if (n >= 20) chk(32'h0, 32'h1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic waitSt(input logic [4:0] s, input int lo, input int hi);
    int b;
    b = cyc;
    rdat = 32'h0;
    while (rdat[4:0] !== s && cyc - b < hi + 20) rd(STATUS_OFS);
    chk(32'(rdat[4:0]), 32'(s));
    chk(32'(cyc - b >= lo && cyc - b <= hi), 32'h1);
  endtask
  // remote pair, sub mute, standby line, supply, over-temp indicator
  task automatic outs(input logic [5:0] e);
    chk(32'({remoteOn, subMute_n, standbyControlLine_n, supplyEn, secondStatusIndicator}), 32'(e));
  endtask
  // lit cycles over two seconds
  task automatic led(input int exp);
    int n;
    n = 0;
    repeat (2 * S) begin
      @(posedge mclk);
      n += 32'(statusLed);
    end
    chk(32'(n), 32'(exp));
  endtask
  initial begin
    repeat (30000) @(posedge mclk);
    chk(32'h0, 32'h1);
    conclude();
  end
  initial begin
    rst();
    rd(CTRL_OFS);
    chk(rdat, {12'h000, HYST_RST, OFF_TEMP_RST, THRESH_RST});
    rd(TIME0_OFS);
    chk(rdat, {STANDBY_STATE_OFF_RST, SILENCE_STANDBY_STATE_RST});
    rd(TIME1_OFS);
    chk(rdat, {BACKLIGHT_RST, MUTE_OFF_RST});
    rd(DISP_OFS);
    chk(rdat, {17'h00000, I2C_ADDR_RST, LOGO_RST});
    rd(8'h20);
    chk(rdat, 32'h0000_0000);
    chk(32'(perr), 32'h0000_0001);
    rd(STATUS_OFS);
    chk(32'(rdat[7:0]), 32'h28);
    apb(1'b1, TIME0_OFS, 32'h0004_0002);
    apb(1'b1, TIME1_OFS, 32'h0003_0003);
    apb(1'b1, CTRL_OFS, 32'hfff4_4618);
    rd(TIME0_OFS);
    chk(rdat, 32'h0004_0002);
    rd(CTRL_OFS);
    chk(rdat, 32'h0004_4618);
    $display("register test done");
    audioLevelIn <= 8'h20;
    waitSt(ST_ON, 0, 12);
    outs(6'h3e);
    led(2 * S);
    repeat (S) @(posedge mclk);
    waitSt(ST_ON, 0, 12);
    tempIn <= 8'h46;
    waitSt(ST_HOT, 0, 12);
    outs(6'h01);
    tempIn <= 8'h42;
    repeat (10) @(posedge mclk);
    waitSt(ST_HOT, 0, 12);
    tempIn <= 8'h41;
    waitSt(ST_ON, 0, 12);
    audioLevelIn <= 8'h18;
    waitSt(ST_STANDBY, 2 * S - 5, 3 * S + 15);
    outs(6'h32);
    led(S);
    waitSt(ST_OFF, 2 * S - 15, 3 * S + 15);
    outs(6'h00);
    chk(32'(backlightEn), 32'h1);
    led(S / 2);
    t0 = cyc;
    while (backlightEn !== 1'b0 && cyc - t0 < 4 * S) @(posedge mclk);
    chk(32'(cyc - t0 <= 2 * S), 32'h1);
    chk(32'(nBytes > 0), 32'h1);
    chk(32'(addrByte), 32'({I2C_ADDR_RST, 1'b0}));
    nackMode <= 1'b1;
    repeat (500) @(posedge mclk);
    rd(STATUS_OFS);
    chk(32'(rdat[7]), 32'h1);
    nackMode <= 1'b0;
    repeat (500) @(posedge mclk);
    apb(1'b1, STATUS_OFS, 32'h80);
    rd(STATUS_OFS);
    chk(32'(rdat[7]), 32'h0);
    $display("auto test done");
    muteLineIn <= 1'b0;
    rst();
    rd(STATUS_OFS);
    chk(32'(rdat[5]), 32'h0);
    apb(1'b1, TIME1_OFS, 32'h0003_0003);
    repeat (3 * S) @(posedge mclk);
    waitSt(ST_OFF, 0, 12);
    muteLineIn <= 1'b1;
    waitSt(ST_ON, 0, 12);
    muteLineIn <= 1'b0;
    waitSt(ST_MUTE, 0, 12);
    outs(6'h36);
    led(S);
    muteLineIn <= 1'b1;
    waitSt(ST_ON, 0, 12);
    muteLineIn <= 1'b0;
    waitSt(ST_MUTE, 0, 12);
    waitSt(ST_OFF, 3 * S - 15, 5 * S);
    outs(6'h00);
    $display("manual test done");
    conclude();
  end
endmodule
`default_nettype wire
